// File: rtl/cpldm_pkg.sv
package cpldm_pkg;

  // register-file bytes of the stack pointer
  localparam logic [7:0] RF_SPH = 8'hd8;
  localparam logic [7:0] RF_SPL = 8'hd9;

  // bus word indices; byte address is four times the index
  localparam logic [8:0] IDX_SPH    = {1'b0, RF_SPH};
  localparam logic [8:0] IDX_SPL    = {1'b0, RF_SPL};
  localparam logic [8:0] IDX_INSTR  = 9'h100;
  localparam logic [8:0] IDX_CTRL   = 9'h101;
  localparam logic [8:0] IDX_STATUS = 9'h102;
  localparam logic [8:0] IDX_PC     = 9'h103;
  localparam logic [8:0] IDX_IP     = 9'h104;
  localparam logic [8:0] IDX_FLAGS  = 9'h105;

  localparam int unsigned CTRL_GO = 0;
  localparam int unsigned CTRL_RP = 4;
  localparam int unsigned ST_BUSY = 0;
  localparam int unsigned ST_ILL  = 1;
  localparam int unsigned FL_C    = 7;
  localparam int unsigned FL_Z    = 6;
  localparam int unsigned FL_S    = 5;
  localparam int unsigned FL_V    = 4;
  localparam int unsigned FL_D    = 3;
  localparam int unsigned FL_H    = 2;

  localparam logic [15:0] PC_RST    = 16'h0000;
  localparam logic [15:0] IP_RST    = 16'h0000;
  localparam logic [15:0] IP_STEP   = 16'h0002;
  localparam logic [15:0] PAIR_STEP = 16'h0001;
  localparam logic [7:0]  FLAGS_RST = 8'h00;
  localparam logic [3:0]  RP_RST    = 4'h0;

  localparam logic [7:0] OP_STPI   = 8'hf3;
  localparam logic [7:0] OP_LDW_RR = 8'hc4;
  localparam logic [7:0] OP_LDW_RI = 8'hc5;
  localparam logic [7:0] OP_LDW_IM = 8'hc6;
  localparam logic [7:0] OP_MUL_R  = 8'h84;
  localparam logic [7:0] OP_MUL_I  = 8'h85;
  localparam logic [7:0] OP_MUL_M  = 8'h86;
  localparam logic [7:0] OP_NEXT   = 8'h0f;
  localparam logic [7:0] OP_NOP    = 8'hff;
  localparam logic [7:0] OP_OR_WW  = 8'h42;
  localparam logic [7:0] OP_OR_WI  = 8'h43;
  localparam logic [7:0] OP_OR_RR  = 8'h44;
  localparam logic [7:0] OP_OR_RI  = 8'h45;
  localparam logic [7:0] OP_OR_IM  = 8'h46;
  localparam logic [7:0] OP_POP_R  = 8'h50;
  localparam logic [7:0] OP_POP_I  = 8'h51;

  localparam logic [4:0] CYC_STPI = 5'h0e;
  localparam logic [4:0] CYC_LDW  = 5'h08;
  localparam logic [4:0] CYC_MUL  = 5'h16;
  localparam logic [4:0] CYC_NEXT = 5'h0a;
  localparam logic [4:0] CYC_NOP  = 5'h04;
  localparam logic [4:0] CYC_OR_S = 5'h04;
  localparam logic [4:0] CYC_OR_L = 5'h06;
  localparam logic [4:0] CYC_POP  = 5'h08;
  localparam logic [4:0] CYC_ILL  = 5'h01;

  typedef enum logic [2:0] {S_IDLE, S_EXEC, S_SPUPD, S_MEM, S_HOLD} cpldm_state_e;

  typedef struct packed {
    logic        req;
    logic        we;
    logic        data_space;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } cpldm_mem_req_s;

  typedef struct packed {
    logic       known;
    logic [2:0] len;
    logic [4:0] cyc;
  } cpldm_opinfo_s;

  function automatic cpldm_opinfo_s op_info(input logic [7:0] op);
    cpldm_opinfo_s i;
    i = '{known: 1'b1, len: 3'h2, cyc: CYC_OR_L};
    case (op)
      OP_STPI:                      i.cyc = CYC_STPI;
      OP_LDW_RR, OP_LDW_RI:         i = '{1'b1, 3'h3, CYC_LDW};
      OP_LDW_IM:                    i = '{1'b1, 3'h4, CYC_LDW};
      OP_MUL_R, OP_MUL_I, OP_MUL_M: i = '{1'b1, 3'h3, CYC_MUL};
      OP_NEXT:                      i = '{1'b1, 3'h1, CYC_NEXT};
      OP_NOP:                       i = '{1'b1, 3'h1, CYC_NOP};
      OP_OR_WW:                     i.cyc = CYC_OR_S;
      OP_OR_WI:                     i.cyc = CYC_OR_L;
      OP_OR_RR, OP_OR_RI, OP_OR_IM: i.len = 3'h3;
      OP_POP_R, OP_POP_I:           i.cyc = CYC_POP;
      default:                      i = '{1'b0, 3'h1, CYC_ILL};
    endcase
    return i;
  endfunction : op_info

endpackage : cpldm_pkg

// File: rtl/cpldm_alu.sv
`timescale 1ns/100ps
module cpldm_alu import cpldm_pkg::*; (
  input  wire logic        mul,
  input  wire logic [7:0]  a,
  input  wire logic [7:0]  b,
  input  wire logic [7:0]  flags_in,
  output logic      [15:0] res,
  output logic      [7:0]  flags_out
);

  always_comb begin
    flags_out = flags_in;
    if (mul) begin
      res             = {8'h00, a} * {8'h00, b};
      flags_out[FL_C] = |res[15:8];
      flags_out[FL_Z] = (res == 16'h0000);
      flags_out[FL_S] = res[15];
      flags_out[FL_V] = 1'b0;
    end else begin
      res             = {8'h00, a | b};
      flags_out[FL_Z] = (res[7:0] == 8'h00);
      flags_out[FL_S] = res[7];
      flags_out[FL_V] = 1'b0;
    end
  end

endmodule : cpldm_alu

// File: rtl/cpldm_avs.sv
`timescale 1ns/100ps
module cpldm_avs (
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic req,
  input  wire logic allow,
  output logic      waitrequest,
  output logic      accept,
  output logic      take
);

  typedef struct packed {
    logic wait_q;
  } cpldm_avs_s;

  cpldm_avs_s s;
  cpldm_avs_s next_s;

  // one wait cycle at the start of each access keeps the handshake a plain flop
  assign accept      = req & allow & s.wait_q;
  assign take        = req & ~s.wait_q;
  assign waitrequest = s.wait_q;

  always_comb begin
    next_s        = s;
    next_s.wait_q = ~accept;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s.wait_q <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

endmodule : cpldm_avs

// File: rtl/cpldm_core.sv
// The Avalon-MM register port was chosen for this implementation.
`timescale 1ns/100ps
// Behaviour
// - the pre-increment store bumps the pair first, then writes the source byte to memory.
// - an even pair field stores to program memory, an odd one to external data memory.
// - the word load copies a 16-bit source into a pair in 8 cycles, flags untouched.
// - multiply puts the even register times the source into the pair in 22 cycles.
// - multiply sets carry above 255, zero, sign from bit 15, clears overflow.
// - NEXT loads the program counter from the word at the pointer, then adds 2 to it.
// - no-operation takes one byte and 4 cycles and only advances the program counter.
// - the logical OR writes destination or source back into the destination.
// - after OR zero and sign follow the result, overflow clears, carry stays.
// - pop loads the destination from the stack location, then adds one to the pointer.
// - pop leaves every flag as it was.
// - the stack pointer lives in register-file bytes d8 (high) and d9 (low).
module cpldm_core import cpldm_pkg::*; (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic [8:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  output cpldm_mem_req_s   mem_req,
  input  wire logic        mem_ack,
  input  wire logic [15:0] mem_rdata,
  output logic             busy
);

  typedef struct packed {
    cpldm_state_e   st;
    logic           busy;
    logic [31:0]    instr;
    logic [3:0]     rp;
    logic [4:0]     cnt;
    logic [15:0]    pc;
    logic [15:0]    ip;
    logic [7:0]     flags;
    logic           ill;
    logic [15:0]    sp_nx;
    logic [31:0]    rdata;
    cpldm_mem_req_s mem;
  } cpldm_core_s;

  cpldm_core_s   s;
  cpldm_core_s   next_s;
  logic [7:0]    rf [256];
  logic          rf_we0;
  logic          rf_we1;
  logic [7:0]    rf_wa0;
  logic [7:0]    rf_wa1;
  logic [7:0]    rf_wd0;
  logic [7:0]    rf_wd1;
  logic          pair_we;
  logic [7:0]    pa;
  logic [15:0]   pd;
  logic [7:0]    op;
  logic [7:0]    b1;
  logic [7:0]    b2;
  logic [7:0]    b3;
  logic [3:0]    hi;
  logic [3:0]    lo;
  cpldm_opinfo_s info;
  logic [7:0]    dst_a;
  logic [7:0]    src_v;
  logic          alu_mul;
  logic [15:0]   alu_res;
  logic [7:0]    alu_flags;
  logic [15:0]   sp;
  logic [7:0]    stpi_pa;
  logic [15:0]   stpi_inc;
  logic [7:0]    stpi_src;
  logic          stpi_odd;
  logic          allow;
  logic          acc;
  logic          take;
  logic [31:0]   rd_mux;

  function automatic logic [7:0] wreg(input logic [3:0] base, input logic [3:0] n);
    return {base, n};
  endfunction : wreg

  function automatic logic [7:0] inc8(input logic [7:0] a);
    return a + 8'h01;
  endfunction : inc8

  assign op   = s.instr[7:0];
  assign b1   = s.instr[15:8];
  assign b2   = s.instr[23:16];
  assign b3   = s.instr[31:24];
  assign hi   = b1[7:4];
  assign lo   = b1[3:0];
  assign info = op_info(op);
  assign sp   = {rf[RF_SPH], rf[RF_SPL]};

  assign stpi_pa  = wreg(s.rp, {lo[3:1], 1'b0});
  assign stpi_inc = {rf[stpi_pa], rf[inc8(stpi_pa)]} + PAIR_STEP;
  assign stpi_src = rf[wreg(s.rp, hi)];
  assign stpi_odd = lo[0];

  // status stays readable while an instruction runs; all else waits for idle
  assign allow = (s.st == S_IDLE) || (avs_read && avs_address == IDX_STATUS);

  cpldm_avs u_avs (
    .clk         (clk),
    .srst        (srst),
    .req         (avs_read | avs_write),
    .allow       (allow),
    .waitrequest (avs_waitrequest),
    .accept      (acc),
    .take        (take)
  );

  // operand fetch for the arithmetic and logic forms
  always_comb begin
    dst_a   = 8'h00;
    src_v   = 8'h00;
    alu_mul = 1'b0;
    case (op)
      OP_OR_WW: begin
        dst_a = wreg(s.rp, hi);
        src_v = rf[wreg(s.rp, lo)];
      end
      OP_OR_WI: begin
        dst_a = wreg(s.rp, hi);
        src_v = rf[rf[wreg(s.rp, lo)]];
      end
      OP_OR_RR: begin
        dst_a = b2;
        src_v = rf[b1];
      end
      OP_OR_RI: begin
        dst_a = b2;
        src_v = rf[rf[b1]];
      end
      OP_OR_IM: begin
        dst_a = b1;
        src_v = b2;
      end
      OP_MUL_R, OP_MUL_I, OP_MUL_M: begin
        dst_a   = {b2[7:1], 1'b0};
        alu_mul = 1'b1;
        src_v   = (op == OP_MUL_R) ? rf[b1] : (op == OP_MUL_I) ? rf[rf[b1]] : b1;
      end
      default: ;
    endcase
  end

  cpldm_alu u_alu (
    .mul       (alu_mul),
    .a         (rf[dst_a]),
    .b         (src_v),
    .flags_in  (s.flags),
    .res       (alu_res),
    .flags_out (alu_flags)
  );

  always_comb begin
    case (avs_address)
      IDX_INSTR:  rd_mux = s.instr;
      IDX_CTRL:   rd_mux = {24'h000000, s.rp, 4'h0};
      IDX_STATUS: rd_mux = {16'h0000, s.flags, 6'h00, s.ill, s.busy};
      IDX_PC:     rd_mux = {16'h0000, s.pc};
      IDX_IP:     rd_mux = {16'h0000, s.ip};
      IDX_FLAGS:  rd_mux = {24'h000000, s.flags};
      default:    rd_mux = avs_address[8] ? 32'h00000000 : {24'h000000, rf[avs_address[7:0]]};
    endcase
  end

  always_comb begin
    next_s  = s;
    rf_we0  = 1'b0;
    rf_wa0  = 8'h00;
    rf_wd0  = 8'h00;
    rf_we1  = 1'b0;
    rf_wa1  = 8'h00;
    rf_wd1  = 8'h00;
    pair_we = 1'b0;
    pa      = 8'h00;
    pd      = 16'h0000;
    if (s.cnt != 5'h00) begin
      next_s.cnt = s.cnt - 5'h01;
    end
    if (acc) begin
      next_s.rdata = rd_mux;
    end
    if (take && avs_write) begin
      case (avs_address)
        IDX_INSTR: begin
          for (int i = 0; i < 4; i++) begin
            if (avs_byteenable[i]) begin
              next_s.instr[8*i +: 8] = avs_writedata[8*i +: 8];
            end
          end
        end
        IDX_CTRL: begin
          if (avs_byteenable[0]) begin
            next_s.rp = avs_writedata[CTRL_RP +: 4];
            if (avs_writedata[CTRL_GO]) begin
              next_s.st   = S_EXEC;
              next_s.busy = 1'b1;
              next_s.cnt  = info.cyc - 5'h01;
            end
          end
        end
        IDX_STATUS: begin
          if (avs_byteenable[0] && avs_writedata[ST_ILL]) begin
            next_s.ill = 1'b0;
          end
        end
        IDX_PC: begin
          if (avs_byteenable[0]) next_s.pc[7:0] = avs_writedata[7:0];
          if (avs_byteenable[1]) next_s.pc[15:8] = avs_writedata[15:8];
        end
        IDX_IP: begin
          if (avs_byteenable[0]) next_s.ip[7:0] = avs_writedata[7:0];
          if (avs_byteenable[1]) next_s.ip[15:8] = avs_writedata[15:8];
        end
        IDX_FLAGS: begin
          if (avs_byteenable[0]) next_s.flags = avs_writedata[7:0];
        end
        default: begin
          if (!avs_address[8] && avs_byteenable[0]) begin
            rf_we0 = 1'b1;
            rf_wa0 = avs_address[7:0];
            rf_wd0 = avs_writedata[7:0];
          end
        end
      endcase
    end
    unique case (s.st)
      S_IDLE: ;
      S_EXEC: begin
        next_s.st = S_HOLD;
        next_s.pc = s.pc + {13'h0000, info.len};
        case (op)
          OP_STPI: begin
            pair_we    = 1'b1;
            pa         = stpi_pa;
            pd         = stpi_inc;
            next_s.mem = '{1'b1, 1'b1, stpi_odd, stpi_inc, stpi_src};
            next_s.st  = S_MEM;
          end
          OP_LDW_RR: begin
            pair_we = 1'b1;
            pa      = b2;
            pd      = {rf[b1], rf[inc8(b1)]};
          end
          OP_LDW_RI: begin
            pair_we = 1'b1;
            pa      = b2;
            pd      = {rf[rf[b1]], rf[inc8(rf[b1])]};
          end
          OP_LDW_IM: begin
            pair_we = 1'b1;
            pa      = b1;
            pd      = {b2, b3};
          end
          OP_MUL_R, OP_MUL_I, OP_MUL_M: begin
            pair_we      = 1'b1;
            pa           = dst_a;
            pd           = alu_res;
            next_s.flags = alu_flags;
          end
          OP_OR_WW, OP_OR_WI, OP_OR_RR, OP_OR_RI, OP_OR_IM: begin
            rf_we0       = 1'b1;
            rf_wa0       = dst_a;
            rf_wd0       = alu_res[7:0];
            next_s.flags = alu_flags;
          end
          OP_POP_R, OP_POP_I: begin
            rf_we0       = 1'b1;
            rf_wa0       = (op == OP_POP_R) ? b1 : rf[b1];
            rf_wd0       = rf[sp[7:0]];
            next_s.sp_nx = sp + PAIR_STEP;
            next_s.st    = S_SPUPD;
          end
          OP_NEXT: begin
            next_s.mem = '{1'b1, 1'b0, 1'b0, s.ip, 8'h00};
            next_s.pc  = s.pc;
            next_s.st  = S_MEM;
          end
          OP_NOP: ;
          default: next_s.ill = 1'b1;
        endcase
      end
      S_SPUPD: begin
        // separate cycle so a pop into d8/d9 is overwritten by the pointer
        rf_we0    = 1'b1;
        rf_wa0    = RF_SPH;
        rf_wd0    = s.sp_nx[15:8];
        rf_we1    = 1'b1;
        rf_wa1    = RF_SPL;
        rf_wd1    = s.sp_nx[7:0];
        next_s.st = S_HOLD;
      end
      S_MEM: begin
        if (mem_ack) begin
          next_s.mem.req = 1'b0;
          next_s.st      = S_HOLD;
          if (!s.mem.we) begin
            next_s.pc = mem_rdata;
            next_s.ip = s.ip + IP_STEP;
          end
        end
      end
      S_HOLD: begin
        if (s.cnt == 5'h00) begin
          next_s.st   = S_IDLE;
          next_s.busy = 1'b0;
        end
      end
    endcase
    if (pair_we) begin
      rf_we0 = 1'b1;
      rf_wa0 = pa;
      rf_wd0 = pd[15:8];
      rf_we1 = 1'b1;
      rf_wa1 = inc8(pa);
      rf_wd1 = pd[7:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rf_we0) rf[rf_wa0] <= rf_wd0;
    if (rf_we1) rf[rf_wa1] <= rf_wd1;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s       <= '0;
      s.pc    <= PC_RST;
      s.ip    <= IP_RST;
      s.flags <= FLAGS_RST;
      s.rp    <= RP_RST;
    end else begin
      s <= next_s;
    end
  end

  assign avs_readdata = s.rdata;
  assign mem_req      = s.mem;
  assign busy         = s.busy;

  // checks
  logic mul_c;
  logic or_z;
  assign mul_c = |alu_res[15:8];
  assign or_z  = (alu_res[7:0] == 8'h00);

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence s_exec(logic [7:0] o);
    s.st == S_EXEC && op == o;
  endsequence
  sequence s_pop;
    s_exec(OP_POP_R) ##1 s.st == S_SPUPD;
  endsequence

  a_nop_timing: assert property (s_exec(OP_NOP) |-> ##4
    (s.st == S_IDLE && s.pc == $past(s.pc, 4) + 16'h0001))
    else $error("nop length or pc step wrong");
  a_ldw_timing: assert property (s_exec(OP_LDW_IM) |->
    ##7 s.st == S_HOLD ##1 s.st == S_IDLE)
    else $error("word load does not end after 8 cycles");
  a_mul_cycles: assert property (s_exec(OP_MUL_M) |-> ##22 s.st == S_IDLE)
    else $error("multiply does not end after 22 cycles");
  a_mul_flags: assert property (s.st == S_EXEC && alu_mul |=>
    s.flags[FL_C] == $past(mul_c) && !s.flags[FL_V] && s.flags[FL_H] == $past(s.flags[FL_H]))
    else $error("multiply flags wrong");
  a_or_flags: assert property (s.st == S_EXEC && op inside {[OP_OR_WW:OP_OR_IM]} |=>
    s.flags[FL_C] == $past(s.flags[FL_C]) && !s.flags[FL_V] && s.flags[FL_Z] == $past(or_z))
    else $error("or flags wrong");
  a_pop_sp: assert property (s_pop |=> sp == $past(sp, 2) + 16'h0001)
    else $error("stack pointer not advanced by one");
  a_pop_flags: assert property (s_pop |=> s.flags == $past(s.flags, 2))
    else $error("pop changed the flags");
  a_store_req: assert property (s_exec(OP_STPI) |=> s.mem.req && s.mem.we &&
    s.mem.addr == $past(stpi_inc) && s.mem.wdata == $past(stpi_src))
    else $error("store request wrong");
  a_store_space: assert property (s_exec(OP_STPI) |=> s.mem.data_space == $past(stpi_odd))
    else $error("store memory space wrong");
  a_next_ip: assert property (s.st == S_MEM && mem_ack && !s.mem.we |=>
    s.ip == $past(s.ip) + 16'h0002 && s.pc == $past(mem_rdata))
    else $error("next did not load pc or step pointer");

endmodule : cpldm_core

// File: dv/cpldm_mem_model.sv
`timescale 1ns/100ps
module cpldm_mem_model import cpldm_pkg::*; #(
  parameter logic [15:0] PROG_WORD = 16'h1a34
) (
  input  wire logic           clk,
  input  wire logic           srst,
  input  wire cpldm_mem_req_s mem_req,
  input  wire logic [5:0]     delay_cyc,
  output logic                mem_ack,
  output logic [15:0]         mem_rdata,
  output cpldm_mem_req_s      last_req
);
  logic [5:0] cnt;

  // one-cycle ack after delay_cyc + 1 waiting cycles, so slow memory is easy to mimic
  always_ff @(posedge clk) begin
    if (srst || !mem_req.req || mem_ack) begin
      cnt     <= 6'h00;
      mem_ack <= 1'b0;
    end else begin
      cnt     <= cnt + 6'h01;
      mem_ack <= (cnt == delay_cyc);
    end
    if (srst) begin
      last_req <= '0;
    end else if (mem_req.req && !mem_ack && cnt == delay_cyc) begin
      last_req <= mem_req;
    end
  end

  // word is only driven in the ack cycle; inverse elsewhere so stale reads show
  assign mem_rdata = mem_ack ? PROG_WORD : ~PROG_WORD;
endmodule : cpldm_mem_model

// File: dv/tb_cpu_load_unsigned_multiply_or_stack_ops.sv
`timescale 1ns/100ps
module tb_cpu_load_unsigned_multiply_or_stack_ops import cpldm_pkg::*; ;
  logic           clk;
  logic           srst;
  logic [8:0]     avs_address;
  logic           avs_read;
  logic           avs_write;
  logic [31:0]    avs_writedata;
  logic [31:0]    avs_readdata;
  logic           avs_waitrequest;
  cpldm_mem_req_s mem_req;
  cpldm_mem_req_s last_req;
  logic           mem_ack;
  logic [15:0]    mem_rdata;
  logic           busy;
  logic [5:0]     mem_delay;
  logic [31:0]    q;
  int             bad_count;
  int             n_checks;

  cpldm_core u_dut (
    .clk            (clk),
    .srst           (srst),
    .avs_address    (avs_address),
    .avs_read       (avs_read),
    .avs_write      (avs_write),
    .avs_writedata  (avs_writedata),
    .avs_byteenable (4'hf),
    .avs_readdata   (avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .mem_req        (mem_req),
    .mem_ack        (mem_ack),
    .mem_rdata      (mem_rdata),
    .busy           (busy)
  );

  cpldm_mem_model u_mem (
    .clk      (clk),
    .srst     (srst),
    .mem_req  (mem_req),
    .delay_cyc(mem_delay),
    .mem_ack  (mem_ack),
    .mem_rdata(mem_rdata),
    .last_req (last_req)
  );

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic give_verdict;
    if (bad_count == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : chk

  // request held until waitrequest is sampled low, then released
  task automatic bus(input logic wr, input logic [8:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    avs_address   <= a;
    avs_write     <= wr;
    avs_read      <= ~wr;
    avs_writedata <= d;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (avs_waitrequest === 1'b0) break;
    end
    q = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    if (n == 40) begin
      chk(32'h0, 32'h1, "bus timeout");
      give_verdict();
    end
  endtask : bus

  task automatic wr(input logic [8:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rc(input logic [8:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q, e, "register read");
  endtask : rc

  task automatic fl(input logic [7:0] e);
    bus(1'b0, IDX_STATUS, 32'h0);
    chk({24'h0, q[15:8]}, {24'h0, e}, "flags");
  endtask : fl

  // starts one instruction and counts its busy cycles; cyc 0 skips the count
  task automatic run(input logic [31:0] instr, input logic [3:0] rp, input int cyc);
    int n;
    int hi;
    wr(IDX_INSTR, instr);
    wr(IDX_CTRL, {24'h0, rp, 4'h1});
    hi = 0;
    for (n = 0; n < 200; n++) begin
      @(posedge clk);
      if (busy !== 1'b1) break;
      hi++;
    end
    if (n == 200) begin
      chk(32'h0, 32'h1, "busy stuck");
      give_verdict();
    end
    if (cyc > 0) chk(hi, cyc, "cycle count");
  endtask : run

  task automatic t_regs;
    wr(IDX_SPH, 32'h12);
    wr(IDX_SPL, 32'h34);
    wr(9'h1ff, 32'h5a);
    rc(IDX_SPH, 32'h12);
    rc(IDX_SPL, 32'h34);
    rc(9'h1ff, 32'h0);
  endtask : t_regs

  task automatic t_nop;
    logic [15:0] pc;
    bus(1'b0, IDX_PC, 32'h0);
    pc = q[15:0] + 16'h0001;
    run({24'h0, OP_NOP}, 4'h0, 4);
    rc(IDX_PC, {16'h0, pc});
    fl(8'h00);
  endtask : t_nop

  task automatic t_store;
    wr(8'h00, 32'h7f);
    wr(8'h06, 32'h21);
    wr(8'h07, 32'hff);
    mem_delay <= 6'h01;
    run({16'h0, 8'h06, OP_STPI}, 4'h0, 14);
    chk({5'h0, last_req}, {5'h0, 3'b110, 16'h2200, 8'h7f}, "store");
    rc(8'h06, 32'h22);
    rc(8'h07, 32'h00);
    rc(8'h00, 32'h7f);
    mem_delay <= 6'h1e;
    run({16'h0, 8'h07, OP_STPI}, 4'h0, 0);
    chk({5'h0, last_req}, {5'h0, 3'b111, 16'h2201, 8'h7f}, "data store");
    fl(8'h00);
  endtask : t_store

  task automatic t_ldw;
    wr(8'h10, 32'hab);
    wr(8'h11, 32'hcd);
    wr(8'h16, 32'h10);
    run({8'h0, 8'h12, 8'h10, OP_LDW_RR}, 4'h0, 8);
    rc(8'h12, 32'hab);
    rc(8'h13, 32'hcd);
    rc(8'h10, 32'hab);
    run({8'h34, 8'h12, 8'h14, OP_LDW_IM}, 4'h0, 8);
    rc(8'h15, 32'h34);
    run({8'h0, 8'h18, 8'h16, OP_LDW_RI}, 4'h0, 8);
    rc(8'h18, 32'hab);
    rc(8'h19, 32'hcd);
    fl(8'h00);
  endtask : t_ldw

  task automatic t_unsigned_multiply;
    wr(8'h30, 32'h20);
    wr(8'h32, 32'h09);
    wr(8'h34, 32'h55);
    wr(8'h36, 32'h32);
    wr(8'h38, 32'h03);
    run({8'h0, 8'h34, 8'h00, OP_MUL_M}, 4'h0, 22);
    rc(8'h34, 32'h00);
    fl(8'h40);
    run({8'h0, 8'h38, 8'h36, OP_MUL_I}, 4'h0, 22);
    rc(8'h39, 32'h1b);
    fl(8'h00);
    run({8'h0, 8'h30, 8'h32, OP_MUL_R}, 4'h0, 22);
    rc(8'h30, 32'h01);
    rc(8'h31, 32'h20);
    fl(8'h80);
  endtask : t_unsigned_multiply

  task automatic t_or;
    wr(8'h40, 32'h01);
    wr(8'h41, 32'h0c);
    wr(8'h42, 32'h30);
    wr(8'h43, 32'h41);
    wr(8'h44, 32'h03);
    wr(8'h50, 32'h00);
    wr(8'h51, 32'h00);
    wr(8'h52, 32'h41);
    wr(8'h53, 32'h10);
    run({8'h0, 8'h80, 8'h40, OP_OR_IM}, 4'h0, 6);
    rc(8'h40, 32'h81);
    fl(8'ha0);
    run({8'h0, 8'h42, 8'h41, OP_OR_RR}, 4'h0, 6);
    rc(8'h42, 32'h3c);
    run({8'h0, 8'h44, 8'h43, OP_OR_RI}, 4'h0, 6);
    rc(8'h44, 32'h0f);
    run({16'h0, 8'h32, OP_OR_WI}, 4'h5, 6);
    rc(8'h53, 32'h1c);
    fl(8'h80);
    run({16'h0, 8'h01, OP_OR_WW}, 4'h5, 4);
    rc(8'h50, 32'h00);
    fl(8'hc0);
  endtask : t_or

  task automatic t_pop;
    wr(IDX_SPH, 32'h00);
    wr(IDX_SPL, 32'hfb);
    wr(8'hfb, 32'h55);
    wr(8'hfc, 32'h77);
    wr(8'h62, 32'h64);
    run({16'h0, 8'h60, OP_POP_R}, 4'h0, 8);
    rc(8'h60, 32'h55);
    rc(IDX_SPL, 32'hfc);
    run({16'h0, 8'h62, OP_POP_I}, 4'h0, 8);
    rc(8'h64, 32'h77);
    rc(IDX_SPL, 32'hfd);
    rc(IDX_SPH, 32'h00);
    fl(8'hc0);
  endtask : t_pop

  task automatic t_next;
    mem_delay <= 6'h01;
    run({24'h0, OP_NEXT}, 4'h0, 10);
    chk({16'h0, last_req.we, last_req.data_space, last_req.addr[13:0]}, 32'h0, "fetch");
    rc(IDX_PC, 32'h1a34);
    rc(IDX_IP, 32'h0002);
    fl(8'hc0);
  endtask : t_next

  // undecoded opcode: sticky illegal bit, one-byte step, write-one clears it
  task automatic t_ill;
    logic [15:0] pc;
    bus(1'b0, IDX_PC, 32'h0);
    pc = q[15:0] + 16'h0001;
    run({24'h0, 8'h00}, 4'h0, 2);
    rc(IDX_PC, {16'h0, pc});
    bus(1'b0, IDX_STATUS, 32'h0);
    chk({31'h0, q[ST_ILL]}, 32'h1, "illegal flag set");
    wr(IDX_STATUS, 32'h2);
    bus(1'b0, IDX_STATUS, 32'h0);
    chk({31'h0, q[ST_ILL]}, 32'h0, "illegal flag cleared");
  endtask : t_ill

  initial begin
    srst          = 1'b1;
    avs_address   = 9'h000;
    avs_read      = 1'b0;
    avs_write     = 1'b0;
    avs_writedata = 32'h0;
    mem_delay     = 6'h01;
    bad_count     = 0;
    n_checks      = 0;
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    chk({31'h0, busy}, 32'h0, "busy after reset");
    chk({31'h0, avs_waitrequest}, 32'h1, "waitrequest after reset");
    rc(IDX_PC, 32'h0);
    t_regs();
    t_nop();
    t_store();
    t_ldw();
    t_unsigned_multiply();
    t_or();
    t_pop();
    t_next();
    t_ill();
    give_verdict();
  end
endmodule : tb_cpu_load_unsigned_multiply_or_stack_ops
